// [src/ssx_cfg.svh]
/*
 * Constants of the skip, swap, table-read and exclusive-OR execution block.
 * Assumes inclusion by bare name from every file that needs the figures.
 */
`ifndef SSX_CFG_SVH
`define SSX_CFG_SVH

`define SSX_DATA_W 8
`define SSX_NIBBLE_W 4
`define SSX_PM_ADDR_W 13
`define SSX_PM_WORD_W 16
`define SSX_OFFSET_W 8
`define SSX_HIGH_BYTE_RESET 8'h00
`define SSX_SKIP_CYCLES 2
`define SSX_PLAIN_CYCLES 1
`define SSX_TABLE_CYCLES 2

`endif

// [src/ssx_pkg.sv]
/*
 * Types of the execution block: the instruction group and the sequencer states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package ssx_pkg;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_NIBBLE_SWAP_TO_ACCUM = 4'h1,
        OP_SKIP_WHEN_NULL = 4'h2,
        OP_COPY_AND_SKIP_WHEN_NULL = 4'h3,
        OP_SKIP_BIT_CLEAR = 4'h4,
        OP_TABLE_READ_CURRENT_PAGE = 4'h5,
        OP_TABLE_READ_FINAL_PAGE = 4'h6,
        OP_XOR_TO_ACCUM = 4'h7,
        OP_EXCLUSIVE_OR_TO_MEMORY = 4'h8,
        OP_XOR_LITERAL = 4'h9
    } ssx_op_e;

    typedef enum logic [2:0] {
        ST_READY = 3'b001,
        ST_DUMMY = 3'b010,
        ST_TABLE = 3'b100
    } ssx_state_e;

endpackage : ssx_pkg

`default_nettype wire

// [src/ssx_tbl_fetch.sv]
/*
 * Program memory address generator for table reads.
 * Assumes the program memory answers a request in the cycle the request stands.
 */
`include "ssx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ssx_tbl_fetch #(
    parameter int PA_W = `SSX_PM_ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic final_page,
    input wire logic [PA_W-1:0] pc,
    input wire logic [`SSX_OFFSET_W-1:0] table_pointer_reg,
    output logic [PA_W-1:0] pm_addr_reg,
    output logic pm_req_reg
);

    localparam int PG_W = PA_W - `SSX_OFFSET_W;

    logic [PG_W-1:0] page_next;

    // The final page is the page whose number has every bit set.
    always_comb begin
        page_next = final_page ? {PG_W{1'b1}} : pc[PA_W-1:`SSX_OFFSET_W];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pm_addr_reg <= '0;
        end else if (start) begin
            pm_addr_reg <= {page_next, table_pointer_reg};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pm_req_reg <= 1'b0;
        end else begin
            pm_req_reg <= start;
        end
    end

    a_final_page_addr: assert property (@(posedge clk) disable iff (rst)
        start && final_page |=> pm_req_reg && (&pm_addr_reg[PA_W-1:`SSX_OFFSET_W])
            && pm_addr_reg[`SSX_OFFSET_W-1:0] == $past(table_pointer_reg))
        else $error("Final page table read used the wrong address.");

endmodule : ssx_tbl_fetch

`default_nettype wire

// [src/ssx_exec.sv]
/*
 * Execution unit for nibble swap into the accumulator, zero and bit skips,
 * table reads with the high-byte latch, and the exclusive-OR group.
 * Assumes the core presents the operand byte, accumulator and literal in the
 * cycle the operation is offered, and applies the registered write strobes.
 */
// What this block does
// - Nibble swap puts operand high nibble in accumulator low nibble, memory untouched.
// - Skip-when-null skips the next instruction when the operand byte is zero.
// - A taken skip discards the prefetched instruction and adds one dummy cycle.
// - Copy-and-skip loads the operand into the accumulator and skips if zero.
// - Bit skip skips only when the selected operand bit is clear.
// - Current page table read fetches current page word at the table pointer offset.
// - Table read writes low byte to memory and high byte to the latch.
// - Final page table read fetches from the last page at the pointer offset.
// - Exclusive-OR to accumulator stores result in accumulator, updates only zero flag.
// - Exclusive-OR to memory writes memory, keeps accumulator, updates zero flag.
// - Literal exclusive-OR combines accumulator with literal, updates zero flag.
`include "ssx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module ssx_exec #(
    parameter int PA_W = `SSX_PM_ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire ssx_pkg::ssx_op_e op_code,
    input wire logic [2:0] bit_sel,
    input wire logic [`SSX_DATA_W-1:0] literal,
    input wire logic [`SSX_DATA_W-1:0] mem_rdata,
    input wire logic [`SSX_DATA_W-1:0] acc_in,
    input wire logic [PA_W-1:0] pc,
    input wire logic [`SSX_OFFSET_W-1:0] table_pointer_reg,
    input wire logic [`SSX_PM_WORD_W-1:0] pm_rdata,
    output logic ready_reg,
    output logic skip_reg,
    output logic acc_we_reg,
    output logic [`SSX_DATA_W-1:0] acc_wdata_reg,
    output logic mem_we_reg,
    output logic [`SSX_DATA_W-1:0] mem_wdata_reg,
    output logic z_we_reg,
    output logic z_wdata_reg,
    output logic [`SSX_DATA_W-1:0] table_high_byte_reg,
    output logic [PA_W-1:0] pm_addr_reg,
    output logic pm_req_reg
);

    if (PA_W <= `SSX_OFFSET_W || PA_W > 24) begin : g_bad_width
        $error("PA_W must exceed the table pointer width and stay at or below 24.");
    end

    ssx_pkg::ssx_state_e state_reg;
    ssx_pkg::ssx_state_e state_next;
    logic take;
    logic is_table;
    logic is_final;
    logic skip_next;
    logic [`SSX_DATA_W-1:0] swapped;
    logic [`SSX_DATA_W-1:0] xor_mem;
    logic [`SSX_DATA_W-1:0] xor_lit;

    assign take = op_valid && ready_reg;
    assign is_final = op_code == ssx_pkg::OP_TABLE_READ_FINAL_PAGE;
    assign is_table = op_code == ssx_pkg::OP_TABLE_READ_CURRENT_PAGE || is_final;
    assign xor_mem = acc_in ^ mem_rdata;
    assign xor_lit = acc_in ^ literal;

    // Each result nibble takes the opposite nibble of the operand.
    for (genvar i = 0; i < `SSX_NIBBLE_W; i++) begin : g_swap
        assign swapped[i] = mem_rdata[i + `SSX_NIBBLE_W];
        assign swapped[i + `SSX_NIBBLE_W] = mem_rdata[i];
    end

    always_comb begin
        skip_next = 1'b0;
        unique case (op_code)
            ssx_pkg::OP_SKIP_WHEN_NULL,
            ssx_pkg::OP_COPY_AND_SKIP_WHEN_NULL: begin
                skip_next = mem_rdata == '0;
            end
            ssx_pkg::OP_SKIP_BIT_CLEAR: begin
                skip_next = !mem_rdata[bit_sel];
            end
            default: begin
                skip_next = 1'b0;
            end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ssx_pkg::ST_READY: begin
                if (take && skip_next) begin
                    state_next = ssx_pkg::ST_DUMMY;
                end else if (take && is_table) begin
                    state_next = ssx_pkg::ST_TABLE;
                end
            end
            ssx_pkg::ST_DUMMY: begin
                state_next = ssx_pkg::ST_READY;
            end
            ssx_pkg::ST_TABLE: begin
                state_next = ssx_pkg::ST_READY;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ssx_pkg::ST_READY;
        end else begin
            state_reg <= state_next;
        end
    end

    // Ready falls for the dummy cycle of a skip and for the table fetch cycle.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ready_reg <= 1'b1;
        end else begin
            ready_reg <= state_next == ssx_pkg::ST_READY;
        end
    end

    // One pulse tells the fetch stage to discard its prefetched instruction.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            skip_reg <= 1'b0;
        end else begin
            skip_reg <= take && skip_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_we_reg <= 1'b0;
            acc_wdata_reg <= '0;
        end else begin
            acc_we_reg <= 1'b0;
            if (take) begin
                unique case (op_code)
                    ssx_pkg::OP_NIBBLE_SWAP_TO_ACCUM: begin
                        acc_we_reg <= 1'b1;
                        acc_wdata_reg <= swapped;
                    end
                    ssx_pkg::OP_COPY_AND_SKIP_WHEN_NULL: begin
                        acc_we_reg <= 1'b1;
                        acc_wdata_reg <= mem_rdata;
                    end
                    ssx_pkg::OP_XOR_TO_ACCUM: begin
                        acc_we_reg <= 1'b1;
                        acc_wdata_reg <= xor_mem;
                    end
                    ssx_pkg::OP_XOR_LITERAL: begin
                        acc_we_reg <= 1'b1;
                        acc_wdata_reg <= xor_lit;
                    end
                    default: begin
                        acc_we_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Memory is written by the memory-destination exclusive-OR and by table reads.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_we_reg <= 1'b0;
            mem_wdata_reg <= '0;
        end else if (state_reg == ssx_pkg::ST_TABLE) begin
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= pm_rdata[`SSX_DATA_W-1:0];
        end else if (take && op_code == ssx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY) begin
            mem_we_reg <= 1'b1;
            mem_wdata_reg <= xor_mem;
        end else begin
            mem_we_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            table_high_byte_reg <= `SSX_HIGH_BYTE_RESET;
        end else if (state_reg == ssx_pkg::ST_TABLE) begin
            table_high_byte_reg <= pm_rdata[`SSX_PM_WORD_W-1:`SSX_DATA_W];
        end
    end

    // Only the exclusive-OR group touches a flag, and only the zero flag.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            z_we_reg <= 1'b0;
            z_wdata_reg <= 1'b0;
        end else begin
            z_we_reg <= 1'b0;
            if (take) begin
                if (op_code == ssx_pkg::OP_XOR_TO_ACCUM || op_code == ssx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY) begin
                    z_we_reg <= 1'b1;
                    z_wdata_reg <= xor_mem == '0;
                end else if (op_code == ssx_pkg::OP_XOR_LITERAL) begin
                    z_we_reg <= 1'b1;
                    z_wdata_reg <= xor_lit == '0;
                end
            end
        end
    end

    ssx_tbl_fetch #(
        .PA_W(PA_W)
    ) u_fetch (
        .clk(clk),
        .rst(rst),
        .start(take && is_table),
        .final_page(is_final),
        .pc(pc),
        .table_pointer_reg(table_pointer_reg),
        .pm_addr_reg(pm_addr_reg),
        .pm_req_reg(pm_req_reg)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_zero_skip_issued;
        take && (op_code == ssx_pkg::OP_SKIP_WHEN_NULL) && mem_rdata == '0;
    endsequence

    sequence s_dummy_then_ready;
        skip_reg && !ready_reg ##1 !skip_reg && ready_reg;
    endsequence

    sequence s_table_issued;
        take && is_table;
    endsequence

    sequence s_table_done;
        pm_req_reg && !ready_reg ##1 mem_we_reg && ready_reg;
    endsequence

    a_swap_nibbles: assert property (
        take && op_code == ssx_pkg::OP_NIBBLE_SWAP_TO_ACCUM |=>
            acc_we_reg && !mem_we_reg && acc_wdata_reg == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("Nibble swap result or memory write is wrong.");

    a_zero_skip: assert property (s_zero_skip_issued |=> s_dummy_then_ready)
        else $error("Zero operand did not produce a two-cycle skip.");

    a_no_skip_single: assert property (
        take && !skip_next && !is_table |=> ready_reg && !skip_reg)
        else $error("Non-skipping instruction took more than one cycle.");

    a_copy_skip: assert property (
        take && op_code == ssx_pkg::OP_COPY_AND_SKIP_WHEN_NULL |=>
            acc_we_reg && acc_wdata_reg == $past(mem_rdata) && skip_reg == ($past(mem_rdata) == 8'h00))
        else $error("Copy-and-skip loaded or skipped wrongly.");

    a_bit_skip: assert property (
        take && op_code == ssx_pkg::OP_SKIP_BIT_CLEAR |=> skip_reg == !$past(mem_rdata[bit_sel]))
        else $error("Bit skip followed the wrong bit or sense.");

    a_current_page: assert property (
        take && op_code == ssx_pkg::OP_TABLE_READ_CURRENT_PAGE |=>
            pm_addr_reg == {$past(pc[PA_W-1:8]), $past(table_pointer_reg)})
        else $error("Current page table read used the wrong address.");

    a_table_write: assert property (s_table_issued |=> s_table_done ##0
        mem_wdata_reg == $past(pm_rdata[7:0]) && table_high_byte_reg == $past(pm_rdata[15:8]))
        else $error("Table read bytes went to the wrong places.");

    a_xor_accum: assert property (
        take && op_code == ssx_pkg::OP_XOR_TO_ACCUM |=>
            acc_we_reg && acc_wdata_reg == ($past(acc_in) ^ $past(mem_rdata)) && z_we_reg && !mem_we_reg)
        else $error("Accumulator exclusive-OR result is wrong.");

    a_xor_memory: assert property (
        take && op_code == ssx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY |=>
            mem_we_reg && !acc_we_reg && z_we_reg && z_wdata_reg == (mem_wdata_reg == 8'h00)
            && mem_wdata_reg == ($past(acc_in) ^ $past(mem_rdata)))
        else $error("Memory exclusive-OR result or flag is wrong.");

    a_xor_literal: assert property (
        take && op_code == ssx_pkg::OP_XOR_LITERAL |=>
            acc_we_reg && z_we_reg && !mem_we_reg
            && acc_wdata_reg == ($past(acc_in) ^ $past(literal)) && z_wdata_reg == (acc_wdata_reg == 8'h00))
        else $error("Literal exclusive-OR result or flag is wrong.");

    a_flags_kept: assert property (
        (take && (skip_next || is_table)) ##1 1'b1 |-> !z_we_reg ##1 !z_we_reg)
        else $error("Skip or table read touched the zero flag.");

endmodule : ssx_exec

`default_nettype wire

// [verif/ssx_pm_model.sv]
/*
 * Program memory model that answers the table read requests of the execution block.
 * Assumes a 13-bit word address and that the word is needed in the request cycle.
 */
`timescale 1ns/1ns
`default_nettype none

module ssx_pm_model (
    input wire logic clk,
    input wire logic pm_req,
    input wire logic [12:0] pm_addr,
    output logic [15:0] pm_rdata
);
    logic [15:0] junk_reg = 16'hC35A;

    // Outside a request the bus shows a pattern that changes every cycle, never a stale word.
    always @(posedge clk) begin
        junk_reg <= ~junk_reg ^ {junk_reg[0], 15'h0000};
    end

    // The high byte carries the inverted offset, the low byte address bits 12 to 5, so a wrong page or pointer shows.
    always_comb begin
        pm_rdata = pm_req ? {~pm_addr[7:0], pm_addr[12:5]} : junk_reg;
    end
endmodule : ssx_pm_model

`default_nettype wire

// [verif/skip_swap_table_xor_exec_tb.sv]
/*
 * Self-checking testbench of the execution block with a program memory model.
 * Assumes the default program address width of 13 bits and one clock.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, (a), (e)); end end

module skip_swap_table_xor_exec_tb;
    logic clk = 1'b0;
    logic rst, op_valid, ready_reg, skip_reg, acc_we_reg, mem_we_reg, z_we_reg, z_wdata_reg, pm_req_reg;
    ssx_pkg::ssx_op_e op_code;
    logic [2:0] bit_sel;
    logic [7:0] literal, mem_rdata, acc_in, tp, acc_wdata_reg, mem_wdata_reg, table_high_byte_reg, m_high;
    logic [15:0] exp_q[$];
    logic [12:0] pc, pm_addr_reg;
    logic [15:0] pm_rdata, lfsr, r1, r2;
    int n_fail = 0;
    int total_checks = 0;

    always #4 clk = ~clk;

    ssx_exec dut_u (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .bit_sel(bit_sel),
        .literal(literal), .mem_rdata(mem_rdata), .acc_in(acc_in), .pc(pc), .table_pointer_reg(tp),
        .pm_rdata(pm_rdata), .ready_reg(ready_reg), .skip_reg(skip_reg), .acc_we_reg(acc_we_reg),
        .acc_wdata_reg(acc_wdata_reg), .mem_we_reg(mem_we_reg), .mem_wdata_reg(mem_wdata_reg),
        .z_we_reg(z_we_reg), .z_wdata_reg(z_wdata_reg), .table_high_byte_reg(table_high_byte_reg),
        .pm_addr_reg(pm_addr_reg), .pm_req_reg(pm_req_reg));

    ssx_pm_model pm_u (.clk(clk), .pm_req(pm_req_reg), .pm_addr(pm_addr_reg), .pm_rdata(pm_rdata));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict

    // Offers one operation at a falling edge and checks every result cycle against the model.
    task automatic run_op(input ssx_pkg::ssx_op_e op, input logic [7:0] m, input logic [7:0] a,
                          input logic [7:0] l, input logic [7:0] t, input logic [2:0] b,
                          input logic [12:0] p, input logic refuse);
        logic sk, tb, aw, mw, zw;
        logic [7:0] r;
        logic [12:0] ad;
        logic [15:0] w;
        sk = (op == ssx_pkg::OP_SKIP_WHEN_NULL || op == ssx_pkg::OP_COPY_AND_SKIP_WHEN_NULL) ? m == 8'h00
            : (op == ssx_pkg::OP_SKIP_BIT_CLEAR) && !m[b];
        tb = op inside {ssx_pkg::OP_TABLE_READ_CURRENT_PAGE, ssx_pkg::OP_TABLE_READ_FINAL_PAGE};
        aw = op inside {ssx_pkg::OP_NIBBLE_SWAP_TO_ACCUM, ssx_pkg::OP_COPY_AND_SKIP_WHEN_NULL,
            ssx_pkg::OP_XOR_TO_ACCUM, ssx_pkg::OP_XOR_LITERAL};
        mw = op == ssx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY;
        zw = op inside {ssx_pkg::OP_XOR_TO_ACCUM, ssx_pkg::OP_EXCLUSIVE_OR_TO_MEMORY, ssx_pkg::OP_XOR_LITERAL};
        r = (op == ssx_pkg::OP_NIBBLE_SWAP_TO_ACCUM) ? {m[3:0], m[7:4]}
            : (op == ssx_pkg::OP_COPY_AND_SKIP_WHEN_NULL) ? m
            : (op == ssx_pkg::OP_XOR_LITERAL) ? a ^ l : a ^ m;
        ad = {(op == ssx_pkg::OP_TABLE_READ_FINAL_PAGE) ? 5'h1F : p[12:8], t};
        w = {~ad[7:0], ad[12:5]};
        if (tb) begin
            exp_q.push_back(w);
        end
        op_valid = 1'b1;
        op_code = op;
        mem_rdata = m;
        acc_in = a;
        literal = l;
        tp = t;
        bit_sel = b;
        pc = p;
        @(negedge clk);
        `CHK(ready_reg, ~(sk | tb))
        `CHK(skip_reg, sk)
        `CHK(acc_we_reg, aw)
        if (aw) `CHK(acc_wdata_reg, r)
        `CHK(mem_we_reg, mw)
        if (mw) `CHK(mem_wdata_reg, r)
        `CHK(z_we_reg, zw)
        if (zw) `CHK(z_wdata_reg, r == 8'h00)
        `CHK(pm_req_reg, tb)
        if (tb) `CHK(pm_addr_reg, ad)
        `CHK(table_high_byte_reg, m_high)
        if (sk | tb) begin
            // A different operation offered in the dummy or table fetch cycle must leave no trace.
            op_valid = refuse;
            op_code = ssx_pkg::OP_XOR_TO_ACCUM;
            @(negedge clk);
            if (tb) begin
                w = exp_q.pop_front();
                m_high = w[15:8];
            end
            `CHK(ready_reg, 1'b1)
            `CHK(skip_reg, 1'b0)
            `CHK(acc_we_reg, 1'b0)
            `CHK(z_we_reg, 1'b0)
            `CHK(mem_we_reg, tb)
            if (tb) `CHK(mem_wdata_reg, w[7:0])
            `CHK(table_high_byte_reg, m_high)
        end
    endtask : run_op

    initial begin
        #100000;
        n_fail++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        op_valid = 1'b0;
        op_code = ssx_pkg::OP_NONE;
        bit_sel = 3'h0;
        literal = 8'h00;
        mem_rdata = 8'h00;
        acc_in = 8'h00;
        pc = 13'h0000;
        tp = 8'h00;
        m_high = 8'h00;
        lfsr = 16'h6AE0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        `CHK(ready_reg, 1'b1)
        `CHK(table_high_byte_reg, 8'h00)
        for (int k = 0; k < 10; k++) begin
            run_op(ssx_pkg::ssx_op_e'(4'(k)), 8'h00, 8'h00, 8'h00, 8'hFF, 3'h7, 13'h0A55, 1'b1);
        end
        for (int b = 0; b < 8; b++) begin
            run_op(ssx_pkg::OP_SKIP_BIT_CLEAR, ~(8'h01 << b), 8'h00, 8'h00, 8'h00, 3'(b), 13'h0100, 1'b1);
            run_op(ssx_pkg::OP_SKIP_BIT_CLEAR, 8'h01 << b, 8'h00, 8'h00, 8'h00, 3'(b), 13'h0100, 1'b0);
        end
        $display("test directed done");
        for (int i = 0; i < 300; i++) begin
            lfsr = lfsr_next(lfsr);
            r1 = lfsr;
            lfsr = lfsr_next(lfsr);
            r2 = lfsr;
            lfsr = lfsr_next(lfsr);
            if (r1[3:0] == 4'h0) begin
                r1[15:8] = 8'h00;
            end
            run_op(ssx_pkg::ssx_op_e'(4'(int'(r1[7:4]) % 10)), r1[15:8], r2[5] ? r1[15:8] : r2[15:8],
                r2[7:0], lfsr[7:0], lfsr[10:8], lfsr[12:0], r2[0]);
        end
        $display("test random done");
        run_op(ssx_pkg::OP_TABLE_READ_CURRENT_PAGE, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 13'h0300, 1'b0);
        op_valid = 1'b0;
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        m_high = 8'h00;
        `CHK(ready_reg, 1'b1)
        `CHK(table_high_byte_reg, 8'h00)
        run_op(ssx_pkg::OP_XOR_LITERAL, 8'h00, 8'h3C, 8'h3C, 8'h00, 3'h0, 13'h0000, 1'b0);
        op_valid = 1'b0;
        @(negedge clk);
        `CHK(exp_q.size(), 0)
        $display("test reset done");
        give_verdict();
    end
endmodule : skip_swap_table_xor_exec_tb

`default_nettype wire
